// File: src/pcr_regs.sv
/*
  pcr_regs: power configuration, sensor power enable and command
  registers, with the enables and command pulses they drive.
  assumes: the primary interface logic (same clock) presents one-cycle
  read and write strobes with an 8-bit address; fifo_irq and lp_mode
  come from logic on the same clock.
*/
// Function
// - power configuration resets to 0x03
// - bit 0 enables automatic power saving
// - bit 1 allows low-power buffer reads after interrupt
// - bit 2 enables fast power-up, resets zero
// - enable bit 0 powers auxiliary sensor path
// - bit 1 gyroscope, bit 2 accelerometer enables
// - bit 3 enables temperature sensor
// - command register reads always return zero
// - code 0x02 starts special gyro sequence
// - code 0x03 applies new gyro gain
// - code 0xa0 programs backed registers into nvm
// - code 0xb6 restores every setting to default
`timescale 1ns/100ps
module pcr_regs
  import pcr_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic lp_mode,
  input wire logic fifo_irq,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic aps_en,
  output logic fifo_lp_read_en,
  output logic fast_pwrup_en,
  output logic aux_en,
  output logic gyr_en,
  output logic acc_en,
  output logic temp_en,
  output logic gyro_trig,
  output logic gain_apply,
  output logic nvm_prog,
  output logic fifo_flush,
  output logic soft_rst
);

  typedef struct packed {
    logic [7:0] conf;
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic rd_valid;
    logic irq_seen;
    logic lp_rd_en;
  } pcr_state_t;

  pcr_state_t st_r;
  pcr_state_t st_nxt;
  logic cmd_wr;

  //////////////////////////////////////////////////////////////////////
  // command path; command writes are never stored, only decoded
  assign cmd_wr = reg_wr && (reg_addr == PCR_OFS_CMD);

  pcr_cmd_decode u_dec (
    .clock(clock),
    .sys_rst(sys_rst),
    .cmd_wr(cmd_wr),
    .cmd_code(reg_wdata),
    .gyro_trig(gyro_trig),
    .gain_apply(gain_apply),
    .nvm_prog(nvm_prog),
    .fifo_flush(fifo_flush),
    .soft_rst(soft_rst)
  );

  //////////////////////////////////////////////////////////////////////
  // register file and derived enables
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = reg_rd;
    st_nxt.rdata = PCR_UNMAPPED_READ;
    if (reg_rd) begin
      case (reg_addr)
        PCR_OFS_CONF: st_nxt.rdata = st_r.conf;
        PCR_OFS_CTRL: st_nxt.rdata = st_r.ctrl;
        PCR_OFS_CMD: st_nxt.rdata = PCR_CMD_READ;
        default: st_nxt.rdata = PCR_UNMAPPED_READ;
      endcase
    end
    // reserved bits are masked so they read back as zero
    if (reg_wr && (reg_addr == PCR_OFS_CONF)) begin
      st_nxt.conf = reg_wdata & PCR_CONF_MASK;
    end
    if (reg_wr && (reg_addr == PCR_OFS_CTRL)) begin
      st_nxt.ctrl = reg_wdata & PCR_CTRL_MASK;
    end
    // the interrupt is remembered for the rest of the low-power stay;
    // a new interrupt in the exit cycle still sets it
    if (fifo_irq) begin
      st_nxt.irq_seen = 1'b1;
    end else if (!lp_mode) begin
      st_nxt.irq_seen = 1'b0;
    end
    st_nxt.lp_rd_en = !lp_mode ||
      (st_r.conf[PCR_CONF_FIFO_LP_BIT] && (st_r.irq_seen || fifo_irq));
    // soft reset wins over a write landing in the same cycle;
    // a fifo flush leaves both registers alone
    if (soft_rst) begin
      st_nxt.conf = PCR_CONF_RST;
      st_nxt.ctrl = PCR_CTRL_RST;
      st_nxt.irq_seen = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.conf <= PCR_CONF_RST;
      st_r.ctrl <= PCR_CTRL_RST;
      st_r.rdata <= PCR_CMD_RST;
      st_r.rd_valid <= 1'b0;
      st_r.irq_seen <= 1'b0;
      st_r.lp_rd_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, each straight from the state register
  assign reg_rdata = st_r.rdata;
  assign reg_rd_valid = st_r.rd_valid;
  assign aps_en = st_r.conf[PCR_CONF_APS_BIT];
  assign fifo_lp_read_en = st_r.lp_rd_en;
  assign fast_pwrup_en = st_r.conf[PCR_CONF_FUP_BIT];
  assign aux_en = st_r.ctrl[PCR_CTRL_AUX_BIT];
  assign gyr_en = st_r.ctrl[PCR_CTRL_GYR_BIT];
  assign acc_en = st_r.ctrl[PCR_CTRL_ACC_BIT];
  assign temp_en = st_r.ctrl[PCR_CTRL_TEMP_BIT];

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_conf_wr;
    reg_wr && (reg_addr == PCR_OFS_CONF) && !soft_rst;
  endsequence

  sequence s_ctrl_wr;
    reg_wr && (reg_addr == PCR_OFS_CTRL) && !soft_rst;
  endsequence

  a_conf_reset_val: assert property (
    @(posedge clock) sys_rst |=>
      aps_en && st_r.conf == PCR_CONF_RST && !fast_pwrup_en)
    else $error("configuration reset value wrong");

  a_aps_follows_wr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_conf_wr |=> aps_en == $past(reg_wdata[PCR_CONF_APS_BIT]))
    else $error("power saving enable does not follow write");

  a_lp_read_block: assert property (
    @(posedge clock) disable iff (sys_rst)
    (lp_mode && !st_r.conf[PCR_CONF_FIFO_LP_BIT] && !soft_rst)
      |=> !fifo_lp_read_en)
    else $error("low power buffer read not blocked");

  a_lp_read_irq: assert property (
    @(posedge clock) disable iff (sys_rst)
    (lp_mode && st_r.conf[PCR_CONF_FIFO_LP_BIT] && fifo_irq)
      |=> fifo_lp_read_en)
    else $error("low power buffer read not allowed after interrupt");

  a_fup_follows_wr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_conf_wr |=> fast_pwrup_en == $past(reg_wdata[PCR_CONF_FUP_BIT]))
    else $error("fast power-up does not follow write");

  a_aux_follows_wr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_ctrl_wr |=> aux_en == $past(reg_wdata[PCR_CTRL_AUX_BIT]))
    else $error("auxiliary enable does not follow write");

  a_gyr_acc_enables: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_ctrl_wr |=> {acc_en, gyr_en} ==
      $past(reg_wdata[PCR_CTRL_ACC_BIT:PCR_CTRL_GYR_BIT]))
    else $error("gyro or accel enable wrong");

  a_temp_enable: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_ctrl_wr ##1 (!reg_wr && !soft_rst) |=>
      temp_en == $past(reg_wdata[PCR_CTRL_TEMP_BIT], 2))
    else $error("temperature enable does not hold write");

  a_cmd_reads_zero: assert property (
    @(posedge clock) disable iff (sys_rst)
    reg_rd && (reg_addr == PCR_OFS_CMD) |=>
      reg_rd_valid && reg_rdata == PCR_CMD_READ)
    else $error("command register read not zero");

  a_flush_keeps_cfg: assert property (
    @(posedge clock) disable iff (sys_rst)
    (fifo_flush && !reg_wr) |=> $stable(st_r.conf) && $stable(st_r.ctrl))
    else $error("flush disturbed configuration");

  a_soft_rst_defaults: assert property (
    @(posedge clock) disable iff (sys_rst)
    reg_wr && (reg_addr == PCR_OFS_CMD) && (reg_wdata == PCR_CMD_SOFT_RST)
      |=> soft_rst ##1 (st_r.conf == PCR_CONF_RST &&
      st_r.ctrl == PCR_CTRL_RST))
    else $error("soft reset did not restore defaults");

  // internal state is watched too, so a fault shows before it reaches a pin
  sequence s_cmd_wr;
    cmd_wr && !soft_rst;
  endsequence

  a_ctrl_reset_val: assert property (
    @(posedge clock) sys_rst |=>
      st_r.ctrl == PCR_CTRL_RST && !aux_en && !gyr_en && !temp_en)
    else $error("enable reset value wrong");

  a_fifo_lp_wr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_conf_wr |=> st_r.conf[PCR_CONF_FIFO_LP_BIT] ==
      $past(reg_wdata[PCR_CONF_FIFO_LP_BIT]))
    else $error("low power read bit does not follow write");

  a_acc_follows_wr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_ctrl_wr |=> acc_en == $past(reg_wdata[PCR_CTRL_ACC_BIT]))
    else $error("accel enable does not follow write");

  a_gyr_follows_wr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_ctrl_wr |=> gyr_en == $past(reg_wdata[PCR_CTRL_GYR_BIT]))
    else $error("gyro enable does not follow write");

  a_temp_follows_wr: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_ctrl_wr |=> temp_en == $past(reg_wdata[PCR_CTRL_TEMP_BIT]))
    else $error("temperature enable does not follow write");

  a_conf_stays: assert property (
    @(posedge clock) disable iff (sys_rst)
    !(reg_wr && (reg_addr == PCR_OFS_CONF)) && !soft_rst |=>
      $stable(st_r.conf))
    else $error("configuration changed without a write");

  a_ctrl_stays: assert property (
    @(posedge clock) disable iff (sys_rst)
    !(reg_wr && (reg_addr == PCR_OFS_CTRL)) && !soft_rst |=>
      $stable(st_r.ctrl))
    else $error("enables changed without a write");

  a_gate_awake: assert property (
    @(posedge clock) disable iff (sys_rst)
    !lp_mode |=> fifo_lp_read_en)
    else $error("buffer read gate closed outside low power");

  a_gate_irq_held: assert property (
    @(posedge clock) disable iff (sys_rst)
    (lp_mode && st_r.irq_seen && st_r.conf[PCR_CONF_FIFO_LP_BIT])
      |=> fifo_lp_read_en)
    else $error("buffer read gate closed after remembered interrupt");

  a_irq_latch_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    fifo_irq && !soft_rst |=> st_r.irq_seen)
    else $error("buffer interrupt not remembered");

  a_irq_latch_clear: assert property (
    @(posedge clock) disable iff (sys_rst)
    !lp_mode && !fifo_irq |=> !st_r.irq_seen)
    else $error("remembered interrupt not cleared on wake");

  a_cmd_not_stored: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_cmd_wr |=> $stable(st_r.conf) && $stable(st_r.ctrl))
    else $error("command write touched a register");

  a_read_conf: assert property (
    @(posedge clock) disable iff (sys_rst)
    reg_rd && (reg_addr == PCR_OFS_CONF) |=>
      reg_rd_valid && reg_rdata == $past(st_r.conf))
    else $error("configuration read value wrong");

  a_read_ctrl: assert property (
    @(posedge clock) disable iff (sys_rst)
    reg_rd && (reg_addr == PCR_OFS_CTRL) |=>
      reg_rd_valid && reg_rdata == $past(st_r.ctrl))
    else $error("enable read value wrong");

  a_soft_rst_latch: assert property (
    @(posedge clock) disable iff (sys_rst)
    soft_rst |=> !st_r.irq_seen)
    else $error("soft reset left interrupt remembered");

  a_rdata_idle: assert property (
    @(posedge clock) disable iff (sys_rst)
    !reg_rd |=> !reg_rd_valid && reg_rdata == PCR_UNMAPPED_READ)
    else $error("read data not zero when idle");

  a_rd_valid_pulse: assert property (
    @(posedge clock) disable iff (sys_rst)
    reg_rd |=> reg_rd_valid)
    else $error("read valid missing");

endmodule : pcr_regs

// File: shared/pcr_pkg.sv
/*
  pcr_pkg: offsets, field positions, reset values and command codes of
  the power configuration, sensor power enable and command registers.
  assumes: an 8-bit register address space driven by the primary
  interface logic, which lives outside this block.
*/
package pcr_pkg;

  //////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] PCR_OFS_CONF = 8'h7c;
  localparam logic [7:0] PCR_OFS_CTRL = 8'h7d;
  localparam logic [7:0] PCR_OFS_CMD = 8'h7e;

  //////////////////////////////////////////////////////////////////////
  // field positions
  localparam int PCR_CONF_APS_BIT = 0;
  localparam int PCR_CONF_FIFO_LP_BIT = 1;
  localparam int PCR_CONF_FUP_BIT = 2;
  localparam int PCR_CTRL_AUX_BIT = 0;
  localparam int PCR_CTRL_GYR_BIT = 1;
  localparam int PCR_CTRL_ACC_BIT = 2;
  localparam int PCR_CTRL_TEMP_BIT = 3;

  //////////////////////////////////////////////////////////////////////
  // reset values and writable masks
  localparam logic [7:0] PCR_CONF_RST = 8'h03;
  localparam logic [7:0] PCR_CTRL_RST = 8'h00;
  localparam logic [7:0] PCR_CMD_RST = 8'h00;
  localparam logic [7:0] PCR_CMD_READ = 8'h00;
  localparam logic [7:0] PCR_CONF_MASK = 8'h07;
  localparam logic [7:0] PCR_CTRL_MASK = 8'h0f;
  localparam logic [7:0] PCR_UNMAPPED_READ = 8'h00;

  //////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] PCR_CMD_GYR_TRIG = 8'h02;
  localparam logic [7:0] PCR_CMD_GAIN_APPLY = 8'h03;
  localparam logic [7:0] PCR_CMD_NVM_PROG = 8'ha0;
  localparam logic [7:0] PCR_CMD_FIFO_FLUSH = 8'hb0;
  localparam logic [7:0] PCR_CMD_SOFT_RST = 8'hb6;

endpackage : pcr_pkg

// File: src/pcr_cmd_decode.sv
/*
  pcr_cmd_decode: turns a write to the command register into one-cycle
  action pulses, one per known command code.
  assumes: cmd_wr is a one-cycle strobe on the same clock; unknown codes
  are dropped silently.
*/
`timescale 1ns/100ps
module pcr_cmd_decode
  import pcr_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  output logic gyro_trig,
  output logic gain_apply,
  output logic nvm_prog,
  output logic fifo_flush,
  output logic soft_rst
);

  typedef struct packed {
    logic gyro;
    logic gain;
    logic nvm;
    logic flush;
    logic srst;
  } pcr_dec_t;

  pcr_dec_t st_r;
  pcr_dec_t st_nxt;

  //////////////////////////////////////////////////////////////////////
  // decode; each pulse lasts one cycle per strobe cycle, so a held strobe keeps its pulse high
  always_comb begin
    st_nxt = '0;
    if (cmd_wr) begin
      st_nxt.gyro = (cmd_code == PCR_CMD_GYR_TRIG);
      st_nxt.gain = (cmd_code == PCR_CMD_GAIN_APPLY);
      st_nxt.nvm = (cmd_code == PCR_CMD_NVM_PROG);
      st_nxt.flush = (cmd_code == PCR_CMD_FIFO_FLUSH);
      st_nxt.srst = (cmd_code == PCR_CMD_SOFT_RST);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gyro_trig = st_r.gyro;
  assign gain_apply = st_r.gain;
  assign nvm_prog = st_r.nvm;
  assign fifo_flush = st_r.flush;
  assign soft_rst = st_r.srst;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking dec_cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_cmd(logic [7:0] code);
    cmd_wr && (cmd_code == code);
  endsequence

  a_gyro_trig_pulse: assert property (
    s_cmd(PCR_CMD_GYR_TRIG) |=> gyro_trig && !gain_apply && !soft_rst)
    else $error("gyro trigger pulse missing");

  a_gain_apply_pulse: assert property (
    s_cmd(PCR_CMD_GAIN_APPLY) |=> gain_apply && !gyro_trig)
    else $error("gain apply pulse missing");

  a_nvm_prog_pulse: assert property (
    s_cmd(PCR_CMD_NVM_PROG) |=> nvm_prog && !fifo_flush)
    else $error("nvm program pulse missing");

  a_fifo_flush_once: assert property (
    s_cmd(PCR_CMD_FIFO_FLUSH) ##1 !cmd_wr |-> fifo_flush ##1 !fifo_flush)
    else $error("fifo flush pulse not single cycle");

  a_soft_rst_cause: assert property (
    soft_rst |-> $past(cmd_wr) && ($past(cmd_code) == PCR_CMD_SOFT_RST))
    else $error("soft reset without its command");

endmodule : pcr_cmd_decode

// File: test/pcr_host_model.sv
/*
  pcr_host_model: host side of the register port, one access at a time.
  assumes: same clock as the register block; strobes last one cycle.
*/
`timescale 1ns/100ps
module pcr_host_model
  import pcr_pkg::*;
(
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // idle bus shows inverted values so a stale address never looks valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (reg_rd_valid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(posedge clock);
        #1;
      end
    end
  endtask : read
endmodule : pcr_host_model

// File: test/pcr_regs_tb.sv
/*
  pcr_regs_tb: self-checking bench for the power and command registers.
  assumes: pcr_host_model drives the register port; lp_mode low unless
  the low-power gate is under test.
*/
`timescale 1ns/100ps
module pcr_regs_tb;
  import pcr_pkg::*;
  logic clock, sys_rst, reg_wr, reg_rd, lp_mode, fifo_irq, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, conf_m, ctrl_m, rd, a, d;
  logic reg_rd_valid, aps_en, fifo_lp_read_en, fast_pwrup_en;
  logic aux_en, gyr_en, acc_en, temp_en;
  logic gyro_trig, gain_apply, nvm_prog, fifo_flush, soft_rst;
  logic [7:0] codes [6] = '{PCR_CMD_GYR_TRIG, PCR_CMD_GAIN_APPLY,
    PCR_CMD_NVM_PROG, PCR_CMD_FIFO_FLUSH, 8'h55, PCR_CMD_SOFT_RST};
  int bad_count, checks;
  int unsigned seed;

  pcr_regs dut_u (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .lp_mode(lp_mode), .fifo_irq(fifo_irq), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .aps_en(aps_en),
    .fifo_lp_read_en(fifo_lp_read_en), .fast_pwrup_en(fast_pwrup_en),
    .aux_en(aux_en), .gyr_en(gyr_en), .acc_en(acc_en), .temp_en(temp_en),
    .gyro_trig(gyro_trig), .gain_apply(gain_apply), .nvm_prog(nvm_prog),
    .fifo_flush(fifo_flush), .soft_rst(soft_rst));
  pcr_host_model host_u (.clock(clock), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] exp_read(input logic [7:0] ad);
    if (ad == PCR_OFS_CONF) return conf_m;
    if (ad == PCR_OFS_CTRL) return ctrl_m;
    return 8'h00;
  endfunction : exp_read

  function automatic logic [7:0] exp_pulse(input logic [7:0] c);
    return {3'h0, c == PCR_CMD_GYR_TRIG, c == PCR_CMD_GAIN_APPLY,
      c == PCR_CMD_NVM_PROG, c == PCR_CMD_FIFO_FLUSH, c == PCR_CMD_SOFT_RST};
  endfunction : exp_pulse

  // only valid with lp_mode low, where the read gate must be open
  task automatic chk_levels();
    chk("conf outs", {5'h0, 1'b1, conf_m[2], conf_m[0]},
      {5'h0, fifo_lp_read_en, fast_pwrup_en, aps_en});
    chk("enables", ctrl_m, {4'h0, temp_en, acc_en, gyr_en, aux_en});
  endtask : chk_levels

  task automatic rd_chk(input logic [7:0] ad, input string what);
    host_u.read(ad, rd, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] read valid expected 1 seen 0");
      finish_test();
    end
    chk(what, exp_read(ad), rd);
  endtask : rd_chk

  task automatic gate_chk(input logic exp);
    chk("read gate", {7'h0, exp}, {7'h0, fifo_lp_read_en});
  endtask : gate_chk

  //////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(51206);
    {sys_rst, lp_mode, fifo_irq, bad_count, checks} = {3'b100, 64'h0};
    conf_m = PCR_CONF_RST;
    ctrl_m = PCR_CTRL_RST;
    repeat (10) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk_levels();
    rd_chk(PCR_OFS_CONF, "conf reset");
    rd_chk(PCR_OFS_CTRL, "ctrl reset");
    for (int i = 0; i < 14; i++) begin
      d = (i < 2) ? {8{i[0]}} : 8'($urandom);
      a = i[0] ? PCR_OFS_CONF : PCR_OFS_CTRL;
      host_u.write(a, d);
      if (i[0]) conf_m = d & PCR_CONF_MASK;
      else ctrl_m = d & PCR_CTRL_MASK;
      chk_levels();
      rd_chk(a, "readback");
    end
    host_u.write(8'h7f, 8'hff);
    rd_chk(8'h7f, "unmapped");
    host_u.write(PCR_OFS_CMD, 8'h55);
    rd_chk(PCR_OFS_CMD, "cmd read");
    host_u.write(PCR_OFS_CONF, 8'h04);
    host_u.write(PCR_OFS_CTRL, 8'h0f);
    {conf_m, ctrl_m} = 16'h040f;
    foreach (codes[k]) begin
      host_u.write(PCR_OFS_CMD, codes[k]);
      chk("pulses", exp_pulse(codes[k]), {3'h0, gyro_trig, gain_apply,
        nvm_prog, fifo_flush, soft_rst});
      @(posedge clock);
      #1;
      chk("pulse end", 8'h00, {3'h0, gyro_trig, gain_apply, nvm_prog,
        fifo_flush, soft_rst});
      if (codes[k] == PCR_CMD_SOFT_RST) {conf_m, ctrl_m} = 16'h0300;
      chk_levels();
    end
    host_u.write(PCR_OFS_CTRL, 8'h0a);
    sys_rst = 1'b1;
    @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk_levels();
    host_u.write(PCR_OFS_CONF, 8'h03);
    lp_mode = 1'b1;
    @(posedge clock);
    #1;
    gate_chk(1'b0);
    fifo_irq = 1'b1;
    @(posedge clock);
    #1;
    fifo_irq = 1'b0;
    repeat (3) begin
      gate_chk(1'b1);
      @(posedge clock);
      #1;
    end
    lp_mode = 1'b0;
    host_u.write(PCR_OFS_CONF, 8'h01);
    lp_mode = 1'b1;
    fifo_irq = 1'b1;
    @(posedge clock);
    #1;
    fifo_irq = 1'b0;
    gate_chk(1'b0);
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    finish_test();
  end
endmodule : pcr_regs_tb
